/* File: pce_pkg.sv */
/*
 * Package for the PCIe capability-2 and error reporting register slice.
 * Holds offsets, field positions, reset values and constant fields.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package pce_pkg;
    // Byte offsets
    localparam logic [11:0] PCE_OFF_DEV_STAT2  = 12'h0E8;
    localparam logic [11:0] PCE_OFF_LINK_CAP2  = 12'h0EC;
    localparam logic [11:0] PCE_OFF_LINK_CS2   = 12'h0F0;
    localparam logic [11:0] PCE_OFF_SLOT_CAP2  = 12'h0F4;
    localparam logic [11:0] PCE_OFF_SLOT_CS2   = 12'h0F8;
    localparam logic [11:0] PCE_OFF_ERR_HDR    = 12'h100;
    localparam logic [11:0] PCE_OFF_UNCOR_STAT = 12'h104;
    localparam logic [11:0] PCE_OFF_IRQ_MASK   = 12'h180;
    // Link control 2 fields
    localparam int          PCE_LC_SPEED_LSB   = 0;
    localparam int          PCE_LC_DEEMP_BIT   = 6;
    localparam int          PCE_LS_CUR_DEEMP   = 16;
    localparam logic [15:0] PCE_LC_RW_MASK     = 16'h1FBF;
    localparam logic [15:0] PCE_LC_RESET       = 16'h0002;
    // Error reporting header fields
    localparam logic [15:0] PCE_HDR_CAP_ID     = 16'h0001;
    localparam logic [3:0]  PCE_HDR_VERSION    = 4'h1;
    localparam logic [11:0] PCE_HDR_NEXT_PTR   = 12'h140;
    // Uncorrectable_error_flags implemented bits
    localparam logic [31:0] PCE_UE_IMPL_MASK   = 32'h003F_F011;
    localparam logic [31:0] PCE_ZERO_WORD      = 32'h0000_0000;
    // AHB-Lite transfer type bit for an active transfer
    localparam int          PCE_HTRANS_ACT_BIT = 1;
endpackage : pce_pkg

/* File: pce_regs.sv */
/*
 * Capability-2 and uncorrectable_error_flags register slice of one port.
 * Assumes an AHB-Lite master issuing single word transfers, event pulses
 * from the port's link and transaction logic, and a strap that says
 * whether the port faces downstream. Transfer size is not decoded: only
 * whole-word accesses are expected. Event pulses last one clock each.
 */
`timescale 1ns/100ps
`default_nettype none
module pce_regs
    import pce_pkg::*;
(
    input  wire logic        i_ref_clk,       // Core clock, 10 MHz
    input  wire logic        i_rstn,          // Async reset, active low
    input  wire logic        i_hsel,          // AHB slave select
    input  wire logic [11:0] i_haddr,         // AHB byte address
    input  wire logic [1:0]  i_htrans,        // AHB transfer type
    input  wire logic        i_hwrite,        // AHB write
    input  wire logic [2:0]  i_hsize,         // AHB size
    input  wire logic        i_hready,        // AHB bus ready
    input  wire logic [31:0] i_hwdata,        // AHB write data
    output logic      [31:0] o_hrdata,        // AHB read data
    output logic             o_hreadyout,     // AHB slave ready
    output logic             o_hresp,         // AHB response, OKAY
    input  wire logic        i_downstream,    // Port faces downstream
    input  wire logic        i_deemp_load,    // Load de-emphasis default
    input  wire logic        i_deemp_value,   // Default to load
    input  wire logic        i_cur_deemp_upd, // Update current level
    input  wire logic        i_cur_deemp,     // Current level from link
    input  wire logic [31:0] i_err_event,     // Error event pulses
    output logic      [15:0] o_link_ctrl,     // Link control 2 value
    output logic             o_irq            // Interrupt, active high
);

    // Address phase capture and register state
    logic        wr_pend_q;
    logic [11:0] addr_q;
    logic [15:0] lctl_q;
    logic        lctl_d6;
    logic        cur_deemp_q;
    logic [31:0] ue_q;
    logic [31:0] ue_d;
    logic [31:0] mask_q;
    logic [31:0] rdata_q;

    // Decode of the address phase and of the write pending in the data phase
    wire         addr_act  = i_hsel & i_hready & i_htrans[PCE_HTRANS_ACT_BIT];
    wire         rd_act    = addr_act & ~i_hwrite;
    wire         wr_lctl   = wr_pend_q & (addr_q == PCE_OFF_LINK_CS2);
    wire         wr_ue     = wr_pend_q & (addr_q == PCE_OFF_UNCOR_STAT);
    wire         wr_mask   = wr_pend_q & (addr_q == PCE_OFF_IRQ_MASK);
    wire [31:0]  ue_clr    = wr_ue ? (i_hwdata & PCE_UE_IMPL_MASK)
                                   : PCE_ZERO_WORD;
    wire [31:0]  ue_set    = i_err_event
                           & PCE_UE_IMPL_MASK;
    wire [31:0]  hdr_word  = {PCE_HDR_NEXT_PTR, PCE_HDR_VERSION,
                              PCE_HDR_CAP_ID};
    wire [31:0]  lcs_word  = {15'h0000, cur_deemp_q, lctl_q};
    wire [15:0]  lctl_wr   = (i_hwdata[15:0] & PCE_LC_RW_MASK)
                           | (lctl_q & ~PCE_LC_RW_MASK);

    // Event pulses by status position, named for the checks below
    wire         ev_training  = i_err_event[0];
    wire         ev_dl_proto  = i_err_event[4];
    wire         ev_poisoned  = i_err_event[12];
    wire         ev_fc_proto  = i_err_event[13];
    wire         ev_cpl_tmo   = i_err_event[14];
    wire         ev_cpl_abort = i_err_event[15];
    wire         ev_unexp_cpl = i_err_event[16];
    wire         ev_rx_ovfl   = i_err_event[17];
    wire         ev_malformed = i_err_event[18];
    wire         ev_ecrc      = i_err_event[19];
    wire         ev_unsup_req = i_err_event[20];
    wire         ev_acs_viol  = i_err_event[21];

    // Read data selection; zero-reading registers fall to default
    logic [31:0] rd_sel;
    always_comb
    begin
        case (i_haddr)
            PCE_OFF_LINK_CS2:   rd_sel = lcs_word;
            PCE_OFF_ERR_HDR:    rd_sel = hdr_word;
            PCE_OFF_UNCOR_STAT: rd_sel = ue_q;
            PCE_OFF_IRQ_MASK:   rd_sel = mask_q;
            default:            rd_sel = PCE_ZERO_WORD;
        endcase
    end

    // Sticky status: set wins over clear
    assign ue_d = (ue_q & ~ue_clr) | ue_set;

    // Bus phase tracking
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end
        else
        begin
            wr_pend_q <= addr_act & i_hwrite;
            addr_q    <= i_haddr;
        end
    end

    // Read data register, loaded at address phase
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rdata_q <= PCE_ZERO_WORD;
        else if (rd_act)
            rdata_q <= rd_sel;
    end

    // First edge after reset release loads the strap into bits 6 and 16
    logic strap_done_q;
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_done_q <= 1'b1;
        end
    end

    // Selectable de-emphasis next value
    always_comb
    begin
        if (!strap_done_q)
            lctl_d6 = i_downstream;
        else if (i_deemp_load)
            lctl_d6 = i_deemp_value;
        else
            lctl_d6 = lctl_q[PCE_LC_DEEMP_BIT];
    end

    // Link control 2 register
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            lctl_q <= PCE_LC_RESET;
        else
        begin
            if (wr_lctl)
                lctl_q <= {lctl_wr[15:7], lctl_d6, lctl_wr[5:0]};
            else
                lctl_q[PCE_LC_DEEMP_BIT] <= lctl_d6;
        end
    end

    // Current de-emphasis level
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cur_deemp_q <= 1'b0;
        else if (!strap_done_q)
            cur_deemp_q <= i_downstream;
        else if (i_cur_deemp_upd)
            cur_deemp_q <= i_cur_deemp;
    end

    // Error status and interrupt mask
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ue_q   <= PCE_ZERO_WORD;
            mask_q <= PCE_ZERO_WORD;
        end
        else
        begin
            ue_q <= ue_d;
            if (wr_mask)
                mask_q <= i_hwdata & PCE_UE_IMPL_MASK;
        end
    end

    // Outputs
    assign o_hrdata    = rdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_link_ctrl = lctl_q;
    assign o_irq       = |(ue_q & mask_q);

    // Checks
    a_hdr_const: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        rd_act && i_haddr == PCE_OFF_ERR_HDR |=> o_hrdata == 32'h1401_0001)
        else $error("error header read wrong");
    a_zero_regs: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        rd_act && (i_haddr == PCE_OFF_LINK_CAP2 || i_haddr == PCE_OFF_SLOT_CAP2
        || i_haddr == PCE_OFF_SLOT_CS2 || i_haddr == PCE_OFF_DEV_STAT2)
        |=> o_hrdata == 32'h0000_0000)
        else $error("zero register read nonzero");
    a_ls_upper: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        rd_act && i_haddr == PCE_OFF_LINK_CS2 |=> o_hrdata[31:17] == 15'h0000
        && o_hrdata[15:13] == 3'b000)
        else $error("link status reserved bits set");
    a_ue_rsvd: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (ue_q & 32'hFFC0_0FEE) == 32'h0000_0000)
        else $error("reserved status bit set");
    a_ue_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_err_event[12] |=> ue_q[12])
        else $error("poisoned status not set");
    a_ue_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[0] && !i_err_event[0] |=> !ue_q[0])
        else $error("training status not cleared");
    a_ue_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ue_q[21] && !(wr_ue && i_hwdata[21]) |=> ue_q[21])
        else $error("violation status lost");
    a_deemp_ro: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        strap_done_q && wr_lctl && !i_deemp_load |=> $stable(lctl_q[6]))
        else $error("de-emphasis bit written");
    a_speed_rst: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(strap_done_q) |-> lctl_q[3:0] == 4'h2)
        else $error("target speed reset wrong");
    a_irq_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_poisoned && mask_q[12] && !wr_mask |=> o_irq)
        else $error("interrupt level wrong");
    a_ecrc_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ue_q[19] && !wr_ue |=> ue_q[19])
        else $error("ECRC status lost");
    a_lctl_store: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_lctl |=> (lctl_q & PCE_LC_RW_MASK)
        == ($past(i_hwdata[15:0]) & PCE_LC_RW_MASK))
        else $error("link control write lost");
    a_mask_rsvd: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (mask_q & 32'hFFC0_0FEE) == 32'h0000_0000)
        else $error("reserved mask bit set");
    a_set_wins: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[0] && ev_training |=> ue_q[0])
        else $error("clear beat same-cycle event");

    // Each event sets its own flag
    a_train_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_training |=> ue_q[0])
        else $error("training status not set");
    a_dlp_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_dl_proto |=> ue_q[4])
        else $error("link protocol status not set");
    a_fcp_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_fc_proto |=> ue_q[13])
        else $error("flow control status not set");
    a_cto_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_cpl_tmo |=> ue_q[14])
        else $error("timeout status not set");
    a_cab_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_cpl_abort |=> ue_q[15])
        else $error("abort status not set");
    a_ucpl_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_unexp_cpl |=> ue_q[16])
        else $error("unexpected completion not set");
    a_rxo_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_rx_ovfl |=> ue_q[17])
        else $error("overflow status not set");
    a_mtlp_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_malformed |=> ue_q[18])
        else $error("malformed status not set");
    a_ecrc_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_ecrc |=> ue_q[19])
        else $error("ECRC status not set");
    a_ur_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_unsup_req |=> ue_q[20])
        else $error("unsupported request not set");
    a_acs_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ev_acs_viol |=> ue_q[21])
        else $error("violation status not set");

    // No flag sets without its event
    a_train_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[0] && !ev_training |=> !ue_q[0])
        else $error("training status set alone");
    a_dlp_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[4] && !ev_dl_proto |=> !ue_q[4])
        else $error("link protocol status set alone");
    a_ptlp_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[12] && !ev_poisoned |=> !ue_q[12])
        else $error("poisoned status set alone");
    a_fcp_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[13] && !ev_fc_proto |=> !ue_q[13])
        else $error("flow control status set alone");
    a_cto_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[14] && !ev_cpl_tmo |=> !ue_q[14])
        else $error("timeout status set alone");
    a_cab_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[15] && !ev_cpl_abort |=> !ue_q[15])
        else $error("abort status set alone");
    a_ucpl_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[16] && !ev_unexp_cpl |=> !ue_q[16])
        else $error("unexpected completion set alone");
    a_rxo_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[17] && !ev_rx_ovfl |=> !ue_q[17])
        else $error("overflow status set alone");
    a_mtlp_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[18] && !ev_malformed |=> !ue_q[18])
        else $error("malformed status set alone");
    a_ecrc_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[19] && !ev_ecrc |=> !ue_q[19])
        else $error("ECRC status set alone");
    a_ur_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[20] && !ev_unsup_req |=> !ue_q[20])
        else $error("unsupported request set alone");
    a_acs_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !ue_q[21] && !ev_acs_viol |=> !ue_q[21])
        else $error("violation status set alone");

    // A written one clears the flag when no event comes with it
    a_dlp_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[4] && !ev_dl_proto |=> !ue_q[4])
        else $error("link protocol status not cleared");
    a_ptlp_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[12] && !ev_poisoned |=> !ue_q[12])
        else $error("poisoned status not cleared");
    a_fcp_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[13] && !ev_fc_proto |=> !ue_q[13])
        else $error("flow control status not cleared");
    a_cto_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[14] && !ev_cpl_tmo |=> !ue_q[14])
        else $error("timeout status not cleared");
    a_cab_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[15] && !ev_cpl_abort |=> !ue_q[15])
        else $error("abort status not cleared");
    a_ucpl_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[16] && !ev_unexp_cpl |=> !ue_q[16])
        else $error("unexpected completion not cleared");
    a_rxo_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[17] && !ev_rx_ovfl |=> !ue_q[17])
        else $error("overflow status not cleared");
    a_mtlp_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[18] && !ev_malformed |=> !ue_q[18])
        else $error("malformed status not cleared");
    a_ecrc_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[19] && !ev_ecrc |=> !ue_q[19])
        else $error("ECRC status not cleared");
    a_ur_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[20] && !ev_unsup_req |=> !ue_q[20])
        else $error("unsupported request not cleared");
    a_acs_clr: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && i_hwdata[21] && !ev_acs_viol |=> !ue_q[21])
        else $error("violation status not cleared");
    c_ue_read: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        rd_act && i_haddr == PCE_OFF_UNCOR_STAT ##1 o_hrdata != 32'h0);
    c_set_clear: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_ue && |(i_err_event & i_hwdata & PCE_UE_IMPL_MASK));
    c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_irq));
    c_lctl_wr: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
        wr_lctl ##1 lctl_q[3:0] != 4'h2);

endmodule : pce_regs
`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the capability-2 and error status slice.
 * Assumes pce_pkg and pce_regs are compiled first; drives AHB-Lite itself.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("[ERR] %0t got %h exp %h", $time, g, e); \
        end \
    end
module tb;
    import pce_pkg::*;
    logic        i_ref_clk, i_rstn, i_hsel, i_hwrite, i_hready;
    logic [11:0] i_haddr;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize;
    logic [31:0] i_hwdata, o_hrdata, i_err_event, rd;
    logic        o_hreadyout, o_hresp, i_downstream, i_deemp_load;
    logic        i_deemp_value, i_cur_deemp_upd, i_cur_deemp, o_irq;
    logic [15:0] o_link_ctrl;
    int          n_errors, check_count;
    pce_regs DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hready(i_hready), .i_hwdata(i_hwdata),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .i_downstream(i_downstream), .i_deemp_load(i_deemp_load),
        .i_deemp_value(i_deemp_value), .i_cur_deemp_upd(i_cur_deemp_upd),
        .i_cur_deemp(i_cur_deemp), .i_err_event(i_err_event),
        .o_link_ctrl(o_link_ctrl), .o_irq(o_irq));
    // Slave is the only one, so its ready is the bus ready
    assign i_hready = o_hreadyout;
    // Clock, 100 ns period
    initial
    begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end
    // Verdict and end of run
    task results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Bounded wait for ready sampled high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (o_hreadyout !== 1'b1 && n < 20);
        if (o_hreadyout !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t bus ready timeout", $time);
            results();
        end
    endtask : wait_rdy
    // One single word transfer; entered just after a rising edge
    task automatic ahb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] r);
        i_hsel   <= 1'b1;
        i_haddr  <= a;
        i_hwrite <= w;
        i_htrans <= 2'b10;
        wait_rdy();
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        wait_rdy();
        r = o_hrdata;
    endtask : ahb
    // Reset with the port direction strap set
    task automatic do_reset(input logic ds);
        i_downstream <= ds;
        i_rstn       <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
    endtask : do_reset
    // Read-only words ignore writes and keep their fixed values; the mask word stores only its implemented bits
    task automatic t_const;
        logic [11:0] ad [8];
        logic [31:0] ex [8];
        ad = '{12'h0E8, 12'h0EC, 12'h0F4, 12'h0F8, 12'h100, 12'h104,
               12'h180, 12'h1FC};
        ex = '{0, 0, 0, 0, 32'h1401_0001, 0, 0, 0};
        foreach (ad[i])
        begin
            ahb(ad[i], 1'b0, 32'h0000_0000, rd);
            `CHK(rd, ex[i]);
            ahb(ad[i], 1'b1, 32'hFFFF_FFFF, rd);
            ahb(ad[i], 1'b0, 32'h0000_0000, rd);
            `CHK(rd, (ad[i] == 12'h180) ? 32'h003F_F011 : ex[i]);
            ahb(ad[i], 1'b1, 32'h0000_0000, rd);
            ahb(ad[i], 1'b0, 32'h0000_0000, rd);
            `CHK(rd, ex[i]);
        end
    endtask : t_const
    // Link control 2 writable mask, protected bit 6, status bit 16
    task automatic t_link(input logic ds);
        logic [31:0] b;
        b = {15'h0000, ds, 9'h000, ds, 6'h00};
        ahb(12'h0F0, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, b | 32'h0000_0002);
        ahb(12'h0F0, 1'b1, 32'hFFFF_FFFF, rd);
        ahb(12'h0F0, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, b | 32'h0000_1FBF);
        `CHK(o_link_ctrl, b[15:0] | 16'h1FBF);
        ahb(12'h0F0, 1'b1, 32'h0000_0000, rd);
        ahb(12'h0F0, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, b);
        // Default load and current level update flip both bits
        i_deemp_load    <= 1'b1;
        i_deemp_value   <= ~ds;
        i_cur_deemp_upd <= 1'b1;
        i_cur_deemp     <= ~ds;
        @(posedge i_ref_clk);
        i_deemp_load    <= 1'b0;
        i_cur_deemp_upd <= 1'b0;
        ahb(12'h0F0, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, {15'h0000, ~ds, 9'h000, ~ds, 6'h00});
    endtask : t_link
    // Each event position sets only its own implemented flag
    task automatic t_events;
        logic [31:0] e;
        for (int i = 0; i < 32; i++)
        begin
            e = (32'h0000_0001 << i) & 32'h003F_F011;
            i_err_event <= 32'h0000_0001 << i;
            @(posedge i_ref_clk);
            i_err_event <= 32'h0000_0000;
            ahb(12'h104, 1'b0, 32'h0000_0000, rd);
            `CHK(rd[15:0], e[15:0]);
            `CHK(rd[31:16], e[31:16]);
            `CHK(o_irq, 1'b0);
            ahb(12'h104, 1'b1, 32'hFFFF_FFFF, rd);
        end
        // All events, unmask one, clear it, then clear the rest
        i_err_event <= 32'hFFFF_FFFF;
        @(posedge i_ref_clk);
        i_err_event <= 32'h0000_0000;
        ahb(12'h180, 1'b1, 32'h0000_1000, rd);
        @(negedge i_ref_clk);
        `CHK(o_irq, 1'b1);
        @(posedge i_ref_clk);
        ahb(12'h104, 1'b1, 32'h0000_1000, rd);
        ahb(12'h104, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, 32'h003F_E011);
        `CHK(o_irq, 1'b0);
        ahb(12'h104, 1'b1, 32'hFFFF_FFFF, rd);
        ahb(12'h104, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0000);
        `CHK(o_hresp, 1'b0);
    endtask : t_events
    // Same-cycle event and write-one clear: the event wins
    task automatic t_race;
        i_hsel   <= 1'b1;
        i_haddr  <= 12'h104;
        i_hwrite <= 1'b1;
        i_htrans <= 2'b10;
        wait_rdy();
        i_htrans    <= 2'b00;
        i_hwdata    <= 32'h0000_0001;
        i_err_event <= 32'h0000_0001;
        wait_rdy();
        i_err_event <= 32'h0000_0000;
        ahb(12'h104, 1'b0, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0001);
        ahb(12'h104, 1'b1, 32'h0000_0001, rd);
    endtask : t_race
    // Main sequence
    initial
    begin
        {i_hsel, i_hwrite, i_deemp_load, i_deemp_value} = '0;
        {i_cur_deemp_upd, i_cur_deemp, i_downstream} = '0;
        {i_haddr, i_htrans, i_hwdata, i_err_event} = '0;
        i_hsize = 3'b010;
        i_rstn  = 1'b0;
        n_errors = 0;
        check_count = 0;
        do_reset(1'b1);
        t_link(1'b1);
        t_const();
        t_events();
        t_race();
        do_reset(1'b0);
        t_link(1'b0);
        results();
    end
endmodule : tb
`default_nettype wire
